// File: gpc_port.sv
/*
 * five-pin configurable i/o port with pwm output, periodic input sampling,
 * edge tracking and command/reply exchange reached over an apb slave.
 * assumes one 20 MHz clock; default-function levels come from logic on the
 * same clock; pin levels arrive asynchronously and are synchronised here.
 */
`timescale 1ns/100ps
`include "gpc_port_cfg.svh"

module gpc_port #(
  parameter int NPINS    = 5,                      // number of pins
  parameter int STEP_CYC = `GPC_PWM_STEP_CYC,      // cycles per 1 % pwm step
  parameter int SMP_CYC  = `GPC_SMP_CYC            // cycles per input sample
) (
  input  wire logic        REF_CLK_IN,             // 20 MHz clock
  input  wire logic        SRST_IN,                // sync reset, high
  input  wire logic        PSEL_IN,                // apb select
  input  wire logic        PENABLE_IN,             // apb access phase
  input  wire logic        PWRITE_IN,              // apb write
  input  wire logic [7:0]  PADDR_IN,               // apb byte address
  input  wire logic [31:0] PWDATA_IN,              // apb write data
  output logic      [31:0] PRDATA_OUT,             // apb read data
  output logic             PREADY_OUT,             // apb ready
  output logic             PSLVERR_OUT,            // apb error, unmapped
  input  wire logic [4:0]  GPIO_IN,                // pin levels, async
  input  wire logic [4:0]  DFLT_LEVEL_IN,          // default-function levels
  output logic      [4:0]  GPIO_OUT,               // pin drive level
  output logic      [4:0]  GPIO_OE_N_OUT,          // low while driving
  output logic      [4:0]  GPIO_PU_OUT,            // resistive pullup on
  output logic      [4:0]  GPIO_PD_OUT,            // resistive pulldown on
  output logic      [4:0]  GPIO_SLOW_OUT,          // slow slew drive
  output logic      [4:0]  USER_SEL_OUT            // pin under user control
);

  // counters are 16 and 24 bits wide and the port has five pins
  if (NPINS != 5 || STEP_CYC < 1 || SMP_CYC < 2 ||
      STEP_CYC > 65535 || SMP_CYC > 16777215) begin : g_param_check
    $error("gpc_port: unsupported parameter values");
  end

  // ****************************************************************
  // functions
  // ****************************************************************
  function automatic gpc_pkg::gpc_drive_t gpc_drive(input logic [2:0] code,
                                                    input logic       lvl);
    gpc_pkg::gpc_drive_t d;
    d = '0;
    case (code)
      `GPC_DRV_FAST_PD: begin
        d.drv = lvl;
        d.val = lvl;
        d.pd  = !lvl;
      end
      `GPC_DRV_FAST_PP: begin
        d.drv = 1'b1;
        d.val = lvl;
      end
      `GPC_DRV_PU_FAST: begin
        d.drv = !lvl;
        d.pu  = lvl;
      end
      `GPC_DRV_SLOW_HI: begin
        d.drv  = lvl;
        d.val  = lvl;
        d.slow = 1'b1;
      end
      `GPC_DRV_SLOW_PP: begin
        d.drv  = 1'b1;
        d.val  = lvl;
        d.slow = 1'b1;
      end
      `GPC_DRV_SLOW_LO: begin
        d.drv  = !lvl;
        d.slow = 1'b1;
      end
      // hi-z input, and the reserved code falls safe to hi-z
      default: d = '0;
    endcase
    return d;
  endfunction : gpc_drive

  function automatic logic [4:0] gpc_onehot(input logic [7:0] idx);
    gpc_onehot = (idx < 8'h05) ? 5'(5'h01 << idx[2:0]) : 5'h00;
  endfunction : gpc_onehot

  // ****************************************************************
  // apb decode
  // ****************************************************************
  logic [31:0] cmd_reg;
  logic [31:0] arg_reg;
  logic [7:0]  rtype_reg;
  logic [3:0]  rlen_reg;
  gpc_pkg::gpc_status_t rstat_reg;
  logic [31:0] rdata_reg;

  wire access   = PSEL_IN && PENABLE_IN;
  wire hit_cmd  = PADDR_IN == `GPC_OFS_CMD;
  wire hit_arg  = PADDR_IN == `GPC_OFS_ARG;
  wire hit_rep  = PADDR_IN == `GPC_OFS_REPLY;
  wire hit_rdat = PADDR_IN == `GPC_OFS_RDATA;
  wire hit_boot = PADDR_IN == `GPC_OFS_BOOT;
  wire mapped   = hit_cmd || hit_arg || hit_rep || hit_rdat || hit_boot;
  wire wr_ok    = access && PWRITE_IN && mapped;
  wire cmd_go   = wr_ok && hit_cmd;
  wire boot_save = wr_ok && hit_boot && PWDATA_IN[`GPC_BOOT_SAVE_BIT];
  wire boot_load = wr_ok && hit_boot && PWDATA_IN[`GPC_BOOT_LOAD_BIT];

  // zero wait states: every access completes in its first access cycle
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = access && !mapped;
  assign PRDATA_OUT  = !(access && !PWRITE_IN) ? 32'h0000_0000 :
                       hit_cmd  ? cmd_reg :
                       hit_arg  ? arg_reg :
                       hit_rep  ? {18'h0_0000, rstat_reg, rlen_reg, rtype_reg} :
                       hit_rdat ? rdata_reg : 32'h0000_0000;

  // ****************************************************************
  // command decode
  // ****************************************************************
  wire [7:0] cmd_type = PWDATA_IN[`GPC_CMD_TYPE_LSB +: 8];
  wire [3:0] cmd_len  = PWDATA_IN[`GPC_CMD_LEN_LSB +: 4];
  wire [7:0] cmd_idx  = arg_reg[7:0];
  wire [7:0] cmd_val  = arg_reg[15:8];
  wire [7:0] cmd_fd   = arg_reg[23:16];
  wire       idx_ok   = cmd_idx < 8'(NPINS);
  wire       val_ok   = cmd_val <= `GPC_DUTY_HIGH;
  wire       len_long = cmd_len == `GPC_LEN_CFG_LONG;
  wire       len_cfg  = cmd_len == `GPC_LEN_CFG_SHORT || len_long;
  wire       fd_ok    = !len_long || cmd_fd[7:4] == 4'h0;
  wire       cfg_ok   = cmd_go && cmd_type == `GPC_TYPE_CFG && idx_ok && val_ok
                        && len_cfg && fd_ok;
  wire       qry_ok   = cmd_go && cmd_type == `GPC_TYPE_QRY && idx_ok
                        && cmd_len == `GPC_LEN_QRY;
  wire [4:0] sel      = gpc_onehot(cmd_idx);

  // ****************************************************************
  // pin configuration and boot copy
  // ****************************************************************
  logic [4:0][6:0] duty_reg;
  logic [4:0][3:0] fd_reg;
  logic [4:0][6:0] boot_duty_reg;
  logic [4:0][3:0] boot_fd_reg;

  always_ff @(posedge REF_CLK_IN) begin
    for (int i = 0; i < NPINS; i++) begin
      if (SRST_IN) begin
        duty_reg[i]      <= `GPC_RST_DUTY;
        fd_reg[i]        <= 4'(`GPC_RST_FD >> (4 * i));
        boot_duty_reg[i] <= `GPC_RST_DUTY;
        boot_fd_reg[i]   <= 4'(`GPC_RST_FD >> (4 * i));
      end else begin
        if (boot_load) begin
          duty_reg[i] <= boot_duty_reg[i];
          fd_reg[i]   <= boot_fd_reg[i];
        end else if (cfg_ok && sel[i]) begin
          duty_reg[i] <= cmd_val[6:0];
          if (len_long)
            fd_reg[i] <= cmd_fd[3:0];
        end
        if (boot_save) begin
          boot_duty_reg[i] <= duty_reg[i];
          boot_fd_reg[i]   <= fd_reg[i];
        end
      end
    end
  end

  // ****************************************************************
  // pwm timebase: 100 steps of one percent each
  // ****************************************************************
  logic [15:0] step_reg;
  logic [6:0]  pct_reg;
  wire         step_end = step_reg == 16'(STEP_CYC - 1);

  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      step_reg <= 16'h0000;
      pct_reg  <= 7'h00;
    end else begin
      step_reg <= step_end ? 16'h0000 : step_reg + 16'h0001;
      if (step_end)
        pct_reg <= (pct_reg == 7'(`GPC_PWM_STEPS - 1)) ? 7'h00 : pct_reg + 7'h01;
    end
  end

  // ****************************************************************
  // pin drive
  // ****************************************************************
  logic [4:0] user_lvl;
  logic [4:0] pin_lvl;
  gpc_pkg::gpc_drive_t drv [5];

  always_comb begin
    for (int i = 0; i < 5; i++) begin
      // duty 0 never beats pct, duty 100 always does
      user_lvl[i] = pct_reg < duty_reg[i];
      pin_lvl[i]  = fd_reg[i][`GPC_FD_USER_BIT] ? user_lvl[i]
                                                 : DFLT_LEVEL_IN[i];
      drv[i]      = gpc_drive(fd_reg[i][2:0], pin_lvl[i]);
    end
  end

  logic [4:0] out_reg;
  logic [4:0] oe_n_reg;
  logic [4:0] pu_reg;
  logic [4:0] pd_reg;
  logic [4:0] slow_reg;

  always_ff @(posedge REF_CLK_IN) begin
    for (int i = 0; i < 5; i++) begin
      out_reg[i]  <= SRST_IN ? 1'b0 : drv[i].val;
      oe_n_reg[i] <= SRST_IN ? 1'b1 : !drv[i].drv;
      pu_reg[i]   <= SRST_IN ? 1'b0 : drv[i].pu;
      pd_reg[i]   <= SRST_IN ? 1'b0 : drv[i].pd;
      slow_reg[i] <= SRST_IN ? 1'b0 : drv[i].slow;
    end
  end

  assign GPIO_OUT      = out_reg;
  assign GPIO_OE_N_OUT = oe_n_reg;
  assign GPIO_PU_OUT   = pu_reg;
  assign GPIO_PD_OUT   = pd_reg;
  assign GPIO_SLOW_OUT = slow_reg;
  always_comb begin
    for (int i = 0; i < 5; i++)
      USER_SEL_OUT[i] = fd_reg[i][`GPC_FD_USER_BIT];
  end

  // ****************************************************************
  // input sampling and edge flags
  // ****************************************************************
  logic [4:0]  gin_meta_reg;
  logic [4:0]  gin_sync_reg;
  logic [4:0]  sample_reg;
  logic [4:0]  rise_reg;
  logic [4:0]  fall_reg;
  logic [23:0] smp_cnt_reg;
  wire         tick     = smp_cnt_reg == 24'(SMP_CYC - 1);
  // sampling only on the tick makes the flags bounce-free at 32 Hz
  wire  [4:0]  rise_set = tick ? (gin_sync_reg & ~sample_reg) : 5'h00;
  wire  [4:0]  fall_set = tick ? (~gin_sync_reg & sample_reg) : 5'h00;
  wire  [4:0]  flag_clr = qry_ok ? sel : 5'h00;
  wire  [4:0]  rise_next = (rise_reg & ~flag_clr) | rise_set;           // set wins
  wire  [4:0]  fall_next = (fall_reg & ~flag_clr) | fall_set;

  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      gin_meta_reg <= 5'h00;
      gin_sync_reg <= 5'h00;
      sample_reg   <= 5'h00;
      rise_reg     <= 5'h00;
      fall_reg     <= 5'h00;
      smp_cnt_reg  <= 24'h00_0000;
    end else begin
      gin_meta_reg <= GPIO_IN;
      gin_sync_reg <= gin_meta_reg;
      smp_cnt_reg  <= tick ? 24'h00_0000 : smp_cnt_reg + 24'h00_0001;
      if (tick)
        sample_reg <= gin_sync_reg;
      rise_reg <= rise_next;
      fall_reg <= fall_next;
    end
  end

  // ****************************************************************
  // command, argument and reply registers
  // ****************************************************************
  wire [2:0] qi = cmd_idx[2:0];
  wire [7:0] evt_byte = {5'h00, rise_reg[qi], fall_reg[qi], sample_reg[qi]};

  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      cmd_reg   <= 32'h0000_0000;
      arg_reg   <= 32'h0000_0000;
      rtype_reg <= 8'h00;
      rlen_reg  <= 4'h0;
      rstat_reg <= gpc_pkg::GPC_ST_IDLE;
      rdata_reg <= 32'h0000_0000;
    end else begin
      if (wr_ok && hit_arg)
        arg_reg <= {8'h00, PWDATA_IN[23:0]};
      if (cmd_go) begin
        cmd_reg <= {20'h0_0000, cmd_len, cmd_type};
        if (cfg_ok) begin
          rtype_reg <= `GPC_TYPE_CFG | `GPC_REPLY_FLAG;
          rlen_reg  <= 4'h0;
          rstat_reg <= gpc_pkg::GPC_ST_DONE;
          rdata_reg <= 32'h0000_0000;
        end else if (qry_ok) begin
          rtype_reg <= `GPC_TYPE_QRY | `GPC_REPLY_FLAG;
          rlen_reg  <= `GPC_LEN_QRY_REPLY;
          rstat_reg <= gpc_pkg::GPC_ST_DONE;
          rdata_reg <= {4'h0, fd_reg[qi], 1'b0, duty_reg[qi], evt_byte,
                        cmd_idx};
        end else begin
          rtype_reg <= 8'h00;
          rlen_reg  <= 4'h0;
          rstat_reg <= gpc_pkg::GPC_ST_REJECT;
          rdata_reg <= 32'h0000_0000;
        end
      end
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_query_taken;
    qry_ok && !tick && cmd_idx == 8'h00;
  endsequence

  sequence s_flags_clear;
    !rise_reg[0] && !fall_reg[0];
  endsequence

  a_bad_index_kept: assert property (@(posedge REF_CLK_IN) disable iff (SRST_IN)
    (cmd_go && !idx_ok && !boot_load) |=> $stable(duty_reg) && $stable(fd_reg))
    else $error("reserved index changed a pin");

  a_duty_low: assert property (@(posedge REF_CLK_IN) disable iff (SRST_IN)
    (fd_reg[0][3] && duty_reg[0] == 7'h00) |-> !pin_lvl[0])
    else $error("duty 0 did not hold pin low");

  a_duty_high: assert property (@(posedge REF_CLK_IN) disable iff (SRST_IN)
    (fd_reg[0][3] && duty_reg[0] == 7'h64) |-> pin_lvl[0])
    else $error("duty 100 did not hold pin high");

  a_sample_hold: assert property (@(posedge REF_CLK_IN) disable iff (SRST_IN)
    !tick |=> $stable(sample_reg))
    else $error("sample moved between ticks");

  a_rise_caught: assert property (@(posedge REF_CLK_IN) disable iff (SRST_IN)
    (tick && gin_sync_reg[0] && !sample_reg[0]) |=> rise_reg[0] && sample_reg[0])
    else $error("rising edge not recorded");

  a_cfg_reply: assert property (@(posedge REF_CLK_IN) disable iff (SRST_IN)
    cfg_ok |=> rtype_reg == 8'h62 && rlen_reg == 4'h0 ##1 rtype_reg == 8'h62 || cmd_go)
    else $error("configure reply wrong");

  a_query_clear: assert property (@(posedge REF_CLK_IN) disable iff (SRST_IN)
    s_query_taken |=> s_flags_clear)
    else $error("query left edge flags set");

  a_query_echo: assert property (@(posedge REF_CLK_IN) disable iff (SRST_IN)
    qry_ok |=> rdata_reg[7:0] == $past(cmd_idx) && rdata_reg[31:28] == 4'h0)
    else $error("query reply index wrong");

  a_bad_value: assert property (@(posedge REF_CLK_IN) disable iff (SRST_IN)
    (cmd_go && cmd_type == 8'h22 && cmd_val > 8'h64) |=>
      rstat_reg == gpc_pkg::GPC_ST_REJECT)
    else $error("bad value accepted");

  a_hiz_input: assert property (@(posedge REF_CLK_IN) disable iff (SRST_IN)
    fd_reg[0][2:0] == 3'h2 |=> GPIO_OE_N_OUT[0] || $past(boot_load || cfg_ok))
    else $error("hi-z mode drove the pin");

  a_default_follow: assert property (@(posedge REF_CLK_IN) disable iff (SRST_IN)
    (!fd_reg[0][3] && fd_reg[0][2:0] == 3'h1) |=>
      GPIO_OUT[0] == $past(DFLT_LEVEL_IN[0]) && !GPIO_OE_N_OUT[0])
    else $error("default function not followed");

endmodule : gpc_port

// File: gpc_port_cfg.svh
/*
 * constants of the pin configuration port: register offsets, command codes,
 * field positions, reset values and timing figures.
 * assumes inclusion by bare name from the design files.
 */
`ifndef GPC_PORT_CFG_SVH
`define GPC_PORT_CFG_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define GPC_OFS_CMD       8'h00
`define GPC_OFS_ARG       8'h04
`define GPC_OFS_REPLY     8'h08
`define GPC_OFS_RDATA     8'h0C
`define GPC_OFS_BOOT      8'h10

// ****************************************************************
// command and reply codes, lengths
// ****************************************************************
`define GPC_TYPE_CFG      8'h22
`define GPC_TYPE_QRY      8'h23
`define GPC_REPLY_FLAG    8'h40
`define GPC_LEN_CFG_SHORT 4'h2
`define GPC_LEN_CFG_LONG  4'h3
`define GPC_LEN_QRY       4'h1
`define GPC_LEN_QRY_REPLY 4'h4
`define GPC_DUTY_HIGH     8'h64

// ****************************************************************
// field positions
// ****************************************************************
`define GPC_CMD_TYPE_LSB  0
`define GPC_CMD_LEN_LSB   8
`define GPC_BOOT_SAVE_BIT 0
`define GPC_BOOT_LOAD_BIT 1
`define GPC_FD_USER_BIT   3

// ****************************************************************
// drive mode codes
// ****************************************************************
`define GPC_DRV_FAST_PD   3'h0
`define GPC_DRV_FAST_PP   3'h1
`define GPC_DRV_HIZ       3'h2
`define GPC_DRV_PU_FAST   3'h3
`define GPC_DRV_SLOW_HI   3'h4
`define GPC_DRV_SLOW_PP   3'h5
`define GPC_DRV_SLOW_LO   3'h7

// ****************************************************************
// reset values: function/drive nibble per pin, pin 4 in the top nibble
// ****************************************************************
`define GPC_RST_FD        20'h3_2232
`define GPC_RST_DUTY      7'h00

// ****************************************************************
// timing: clock period, pwm period, sampling period
// ****************************************************************
`define GPC_CLK_PERIOD_NS 50
`define GPC_PWM_PERIOD_NS 10000000
`define GPC_PWM_STEPS     100
`define GPC_SMP_PERIOD_NS 31250000
`define GPC_PWM_STEP_CYC  (`GPC_PWM_PERIOD_NS / `GPC_PWM_STEPS / `GPC_CLK_PERIOD_NS)
`define GPC_SMP_CYC       (`GPC_SMP_PERIOD_NS / `GPC_CLK_PERIOD_NS)

`endif

// File: gpc_pkg.sv
/*
 * types of the pin configuration port.
 * assumes nothing of its surroundings.
 */
package gpc_pkg;

  // per-pin drive decision: enable, level, pullup, pulldown, slow slew
  typedef struct packed {
    logic drv;
    logic val;
    logic pu;
    logic pd;
    logic slow;
  } gpc_drive_t;

  typedef enum logic [1:0] {
    GPC_ST_IDLE,
    GPC_ST_DONE,
    GPC_ST_REJECT
  } gpc_status_t;

endpackage : gpc_pkg

// File: gpc_pin_load.sv
/*
 * pin load model: resolves each pin wire from the port's drive and an
 * outside driver. assumes the bench plays the outside circuitry.
 */
`timescale 1ns/100ps
// ****************************************************************
// pin wire resolution
// ****************************************************************
module gpc_pin_load (
  input  wire logic       clk_in,     // bench clock
  input  wire logic [4:0] out_in,     // port drive level
  input  wire logic [4:0] oe_n_in,    // low while port drives
  input  wire logic [4:0] pu_in,      // pullup on
  input  wire logic [4:0] pd_in,      // pulldown on
  input  wire logic [4:0] ext_en_in,  // outside driver on
  input  wire logic [4:0] ext_val_in, // outside driver level
  output logic      [4:0] lvl_out     // resolved pin level
);
  logic [4:0] last_reg;
  wire  [4:0] float_w = ~ext_en_in & oe_n_in & ~pu_in & ~pd_in;
  // outside driver wins; a floating wire flips so a stale level never passes
  assign lvl_out = (ext_en_in & ext_val_in) | (~ext_en_in & ~oe_n_in & out_in) |
                   (~ext_en_in & oe_n_in & pu_in) | (float_w & ~last_reg);
  always_ff @(posedge clk_in) begin
    // keep only a driven level, so a floating wire settles at its inverse
    last_reg <= (float_w & last_reg) | (~float_w & lvl_out);
  end
endmodule : gpc_pin_load

// File: gpc_port_tb.sv
/*
 * self-checking bench of the pin configuration port over apb.
 * assumes zero wait apb slave and short pwm and sampling counts.
 */
`timescale 1ns/100ps
`include "gpc_port_cfg.svh"
module gpc_port_tb;
  // ****************************************************************
  // signals and instances
  // ****************************************************************
  localparam int STEP = 2;
  localparam int SMP  = 16;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0]  lvl, dflt, gout, oe_n, pu, pd, slow, usel, ext_en, ext_val;
  int          n_mismatch, checked;

  gpc_port #(.STEP_CYC(STEP), .SMP_CYC(SMP)) dut_u (
    .REF_CLK_IN(clk), .SRST_IN(srst), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .GPIO_IN(lvl), .DFLT_LEVEL_IN(dflt),
    .GPIO_OUT(gout), .GPIO_OE_N_OUT(oe_n), .GPIO_PU_OUT(pu), .GPIO_PD_OUT(pd),
    .GPIO_SLOW_OUT(slow), .USER_SEL_OUT(usel));
  gpc_pin_load load_u (.clk_in(clk), .out_in(gout), .oe_n_in(oe_n), .pu_in(pu),
    .pd_in(pd), .ext_en_in(ext_en), .ext_val_in(ext_val), .lvl_out(lvl));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    @(posedge clk);
    // wait as long as the slave asks; only the watchdog ends a hang
    while (pready !== 1'b1) begin
      n++;
      @(posedge clk);
    end
    chk("wait_states", 32'h0000_0000, 32'(n));
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cmd(input logic [7:0] ty, input logic [3:0] len, input logic [23:0] arg,
                     input logic [31:0] rep);
    apb(1'b1, `GPC_OFS_ARG, {8'h00, arg});
    apb(1'b1, `GPC_OFS_CMD, {20'h0_0000, len, ty});
    apb(1'b0, `GPC_OFS_REPLY, 32'h0000_0000);
    chk("reply", rep, rd & 32'h0000_3FFF);
  endtask : cmd

  task automatic qry(input logic [7:0] p, input logic [31:0] e);
    cmd(`GPC_TYPE_QRY, `GPC_LEN_QRY, {16'h0000, p}, 32'h0000_1463);
    apb(1'b0, `GPC_OFS_RDATA, 32'h0000_0000);
    chk("rdata", e, rd);
  endtask : qry

  function automatic logic [4:0] drv_exp(input logic [2:0] m, input logic v);
    // {oe_n, pu, pd, slow, out}
    case ({m, v})
      4'h0:    return 5'h14;
      4'h1:    return 5'h01;
      4'h2:    return 5'h00;
      4'h3:    return 5'h01;
      4'h6:    return 5'h00;
      4'h7:    return 5'h18;
      4'h9:    return 5'h03;
      4'hA:    return 5'h02;
      4'hB:    return 5'h03;
      4'hE:    return 5'h02;
      default: return 5'h10;
    endcase
  endfunction : drv_exp

  task automatic chk_drv(input logic [2:0] m, input logic v);
    logic [4:0] e;
    logic [4:0] k;
    e = drv_exp(m, v);
    // level and slew mean nothing while the pin floats
    k = e[4] ? 5'h1C : 5'h1F;
    repeat (3) @(posedge clk);
    chk("drive", {27'h0, e & k}, {27'h0, {oe_n[0], pu[0], pd[0], slow[0], gout[0]} & k});
  endtask : chk_drv

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    for (int p = 0; p < 5; p++) begin
      qry(p[7:0], {4'h0, 4'(`GPC_RST_FD >> (4 * p)), 16'h0000, p[7:0]});
    end
    chk("user_sel", 32'h0000_0000, {27'h0, usel});
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk("unmapped", 32'h0000_0001, {31'h0, err});
  endtask : t_reset

  task automatic t_modes;
    logic [2:0] ms[8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    foreach (ms[i]) begin
      for (int v = 0; v < 2; v++) begin
        cmd(`GPC_TYPE_CFG, `GPC_LEN_CFG_LONG, {5'h01, ms[i], 8'(100 * v), 8'h00},
            32'h0000_1062);
        chk_drv(ms[i], v[0]);
      end
    end
    chk("user_sel", 32'h0000_0001, {27'h0, usel});
    cmd(`GPC_TYPE_CFG, `GPC_LEN_CFG_SHORT, 24'h00_0000, 32'h0000_1062);
    chk_drv(3'h7, 1'b0);
    cmd(`GPC_TYPE_CFG, `GPC_LEN_CFG_LONG, 24'h01_0000, 32'h0000_1062);
    for (int v = 0; v < 2; v++) begin
      dflt <= {4'h0, v[0]};
      chk_drv(3'h1, v[0]);
    end
  endtask : t_modes

  task automatic t_pwm;
    logic [7:0] ds[3] = '{8'h01, 8'h32, 8'h63};
    int         hi;
    foreach (ds[i]) begin
      cmd(`GPC_TYPE_CFG, `GPC_LEN_CFG_LONG, {8'h09, ds[i], 8'h00}, 32'h0000_1062);
      hi = 0;
      repeat (100 * STEP) begin
        @(posedge clk);
        hi += (gout[0] & ~oe_n[0]);
      end
      chk("pwm_high", 32'(ds[i]) * STEP, 32'(hi));
    end
  endtask : t_pwm

  task automatic t_reject;
    logic [31:0] bad[6] = '{32'h0309_0005, 32'h0309_6500, 32'h0409_0000,
                            32'h0319_0000, 32'h0109_0000, 32'h0100_0005};
    cmd(`GPC_TYPE_CFG, `GPC_LEN_CFG_LONG, 24'h09_6400, 32'h0000_1062);
    repeat (SMP + 8) @(posedge clk);
    qry(8'h00, 32'h0964_0000);
    // with the outside driver gone the pin shows its own high drive
    ext_en[0] <= 1'b0;
    repeat (SMP + 8) @(posedge clk);
    qry(8'h00, 32'h0964_0500);
    foreach (bad[i]) begin
      cmd((i == 5) ? 8'h23 : 8'h22, bad[i][27:24], bad[i][23:0], 32'h0000_2000);
    end
    cmd(8'h24, 4'h1, 24'h00_0000, 32'h0000_2000);
    qry(8'h00, 32'h0964_0100);
    ext_en[0] <= 1'b1;
    repeat (SMP + 8) @(posedge clk);
  endtask : t_reject

  task automatic t_edges;
    logic [4:0] seq[4] = '{5'h0E, 5'h15, 5'h11, 5'h0A};
    cmd(`GPC_TYPE_CFG, `GPC_LEN_CFG_LONG, 24'h0A_0001, 32'h0000_1062);
    repeat (SMP + 8) @(posedge clk);
    qry(8'h01, 32'h0A00_0001);
    // each entry: bit 4 final outside level, bit 3 a pulse before it,
    // bits 2..0 the event byte expected after both
    foreach (seq[i]) begin
      ext_val[1] <= seq[i][4] ^ seq[i][3];
      repeat (SMP + 8) @(posedge clk);
      ext_val[1] <= seq[i][4];
      repeat (SMP + 8) @(posedge clk);
      qry(8'h01, {8'h0A, 8'h00, 5'h00, seq[i][2:0], 8'h01});
    end
  endtask : t_edges

  task automatic t_boot;
    apb(1'b1, `GPC_OFS_BOOT, 32'h0000_0001);
    cmd(`GPC_TYPE_CFG, `GPC_LEN_CFG_LONG, 24'h02_0000, 32'h0000_1062);
    qry(8'h00, 32'h0200_0200);
    apb(1'b1, `GPC_OFS_BOOT, 32'h0000_0002);
    qry(8'h00, 32'h0964_0000);
  endtask : t_boot

  task automatic complete_run;
    if (n_mismatch == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  // ****************************************************************
  // clock, reset, sequence, watchdog
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    {srst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 3'h0, 8'h00, 32'h0000_0000};
    {dflt, ext_en, ext_val, n_mismatch, checked} = {5'h00, 5'h1F, 5'h00, 64'h0};
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    repeat (SMP + 8) @(posedge clk);
    t_reset();
    t_modes();
    t_pwm();
    t_reject();
    t_edges();
    t_boot();
    complete_run();
  end

  initial begin
    #2000000;
    n_mismatch++;
    complete_run();
  end
endmodule : gpc_port_tb
